// *** hw/notcher_feed_press_control.sv ***
/*
  notcher_feed_press_control: feed-to-stop notcher controller. drives the
  four feed outputs, times the end and vee presses, checks stop tolerance,
  learns the stop reaction time. assumes position comes from logic on the
  same clock, while the detect switch arrives from a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module notcher_feed_press_control
  import notcher_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int POS_W = 32
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic DETECT,
  input wire logic [POS_W-1:0] POSITION,
  input wire logic MOVING,
  output logic OUT_FWD,
  output logic OUT_SLOW,
  output logic OUT_REV,
  output logic OUT_RUN,
  output logic END_PRESS,
  output logic V_PRESS,
  output logic TOL_ERROR
);

  initial begin
    if (TICK_LEN < 1 || POS_W < 21 || POS_W > 32) begin
      $error("notcher: unsupported parameter value");
    end
  end

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // detect switch from a pin: two flops before use
  logic det_meta, det_sync, det_prev;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      det_meta <= 1'b0;
      det_sync <= 1'b0;
      det_prev <= 1'b0;
    end else if (CE) begin
      det_meta <= DETECT;
      det_sync <= det_meta;
      det_prev <= det_sync;
    end
  end
  wire det_rise = det_sync & ~det_prev;

  // millisecond tick
  logic [31:0] tick_cnt;
  wire tick = (tick_cnt == 32'(TICK_LEN - 1));
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) tick_cnt <= '0;
    else if (CE) tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
  end
  // tenth-ms sub tick for stop reaction resolution
  wire sub_tick = (tick_cnt % 32'(TICK_LEN / 10 > 0 ? TICK_LEN / 10 : 1)) == 32'h0;

  // registers
  logic [11:0] ctrl;
  logic [13:0] end_press_down_time, end_up_time, v_press_down_time, v_up_time;
  logic [12:0] end_react, v_react;
  logic [19:0] end_die_lead_offset, end_die_trail_offset, v_die_offset, tol, min_slow;
  logic [16:0] stop_react;
  logic [31:0] target, decel_dist, speed;
  logic tol_err, busy_flag;
  logic stop_react_wr;

  wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire bus_wr = bus_req & WB_WE_I;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic [31:0] rd_mux;
  always_comb begin
    unique case (WB_ADR_I)
      CTRL_OFFSET: rd_mux = {20'h0, ctrl};
      STATUS_OFFSET: rd_mux = {29'h0, busy_flag, tol_err, det_sync};
      END_DOWN_OFFSET: rd_mux = {18'h0, end_press_down_time};
      END_UP_OFFSET: rd_mux = {18'h0, end_up_time};
      V_DOWN_OFFSET: rd_mux = {18'h0, v_press_down_time};
      V_UP_OFFSET: rd_mux = {18'h0, v_up_time};
      END_REACT_OFFSET: rd_mux = {19'h0, end_react};
      V_REACT_OFFSET: rd_mux = {19'h0, v_react};
      LEAD_OFFSET: rd_mux = {12'h0, end_die_lead_offset};
      TRAIL_OFFSET: rd_mux = {12'h0, end_die_trail_offset};
      V_DIE_OFFSET: rd_mux = {12'h0, v_die_offset};
      TOL_OFFSET: rd_mux = {12'h0, tol};
      MIN_SLOW_OFFSET: rd_mux = {12'h0, min_slow};
      STOP_REACT_OFFSET: rd_mux = {15'h0, stop_react};
      TARGET_OFFSET: rd_mux = target;
      POS_OFFSET: rd_mux = 32'(POSITION);
      SPEED_OFFSET: rd_mux = speed;
      DECEL_OFFSET: rd_mux = decel_dist;
      default: rd_mux = 32'h0;
    endcase
  end

  wire [31:0] wv_ctrl = lane_merge({20'h0, ctrl}, WB_DAT_I, WB_SEL_I);
  wire [31:0] wv_any = lane_merge(32'h0, WB_DAT_I, WB_SEL_I);

  // write strobes, one per register
  wire wr_ctrl = bus_wr & hit(WB_ADR_I, CTRL_OFFSET);
  wire wr_end_down = bus_wr & hit(WB_ADR_I, END_DOWN_OFFSET);
  wire wr_end_up = bus_wr & hit(WB_ADR_I, END_UP_OFFSET);
  wire wr_v_down = bus_wr & hit(WB_ADR_I, V_DOWN_OFFSET);
  wire wr_v_up = bus_wr & hit(WB_ADR_I, V_UP_OFFSET);
  wire wr_end_react = bus_wr & hit(WB_ADR_I, END_REACT_OFFSET);
  wire wr_v_react = bus_wr & hit(WB_ADR_I, V_REACT_OFFSET);
  wire wr_lead = bus_wr & hit(WB_ADR_I, LEAD_OFFSET);
  wire wr_trail = bus_wr & hit(WB_ADR_I, TRAIL_OFFSET);
  wire wr_v_die = bus_wr & hit(WB_ADR_I, V_DIE_OFFSET);
  wire wr_tol = bus_wr & hit(WB_ADR_I, TOL_OFFSET);
  wire wr_min_slow = bus_wr & hit(WB_ADR_I, MIN_SLOW_OFFSET);
  wire wr_target = bus_wr & hit(WB_ADR_I, TARGET_OFFSET);
  wire wr_decel = bus_wr & hit(WB_ADR_I, DECEL_OFFSET);
  // out-of-range entries are pinned to the limit, not refused
  wire [13:0] dwell_w = 14'(clamp(wv_any, 32'(DWELL_MIN), 32'(DWELL_MAX)));
  wire [12:0] react_w = 13'(clamp(wv_any, 32'h0, 32'(REACT_MAX)));
  wire [19:0] tol_w = 20'(clamp(wv_any, 32'(TOL_MIN), 32'(TOL_MAX)));

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else if (CE) begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ctrl <= {10'h0, STOP_AUTO} << CTRL_STOP_MODE_LSB;
      end_press_down_time <= DWELL_RESET;
      end_up_time <= DWELL_RESET;
      v_press_down_time <= DWELL_RESET;
      v_up_time <= DWELL_RESET;
      end_react <= '0;
      v_react <= '0;
      end_die_lead_offset <= '0;
      end_die_trail_offset <= '0;
      v_die_offset <= '0;
      tol <= TOL_RESET;
      min_slow <= '0;
      target <= '0;
      decel_dist <= '0;
    end else if (CE) begin
      ctrl[CTRL_GO_BIT] <= 1'b0;
      ctrl[CTRL_ERR_CLR_BIT] <= 1'b0;
      if (wr_ctrl) ctrl <= wv_ctrl[11:0];
      if (wr_end_down) end_press_down_time <= dwell_w;
      if (wr_end_up) end_up_time <= dwell_w;
      if (wr_v_down) v_press_down_time <= dwell_w;
      if (wr_v_up) v_up_time <= dwell_w;
      if (wr_end_react) end_react <= react_w;
      if (wr_v_react) v_react <= react_w;
      if (wr_lead) end_die_lead_offset <= wv_any[19:0];
      if (wr_trail) end_die_trail_offset <= wv_any[19:0];
      if (wr_v_die) v_die_offset <= wv_any[19:0];
      if (wr_tol) tol <= tol_w;
      if (wr_min_slow) min_slow <= wv_any[19:0];
      if (wr_target) target <= wv_any;
      if (wr_decel) decel_dist <= wv_any;
    end
  end
  assign stop_react_wr = bus_wr & hit(WB_ADR_I, STOP_REACT_OFFSET);

  wire [1:0] stop_mode = ctrl[CTRL_STOP_MODE_LSB +: 2];
  wire two_speed = ctrl[CTRL_TWO_SPEED_BIT];
  wire fast_slow = ctrl[CTRL_FAST_SLOW_BIT];
  wire press_vee = ctrl[CTRL_PRESS_SEL_BIT];
  wire flying = ctrl[CTRL_FLYING_BIT];

  // speed estimate: position change per ms
  logic [POS_W-1:0] pos_last;
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      pos_last <= '0;
      speed <= '0;
    end else if (CE && tick) begin
      pos_last <= POSITION;
      speed <= 32'(POSITION - pos_last);
    end
  end

  // distances; position counts from the detect switch
  wire [31:0] die_off = press_vee ? {12'h0, v_die_offset} : {12'h0, end_die_lead_offset};
  wire [31:0] past = 32'(POSITION) - die_off;
  wire [31:0] remain = (target > past) ? target - past : 32'h0;
  // stop reaction in 0.1 ms times speed per ms gives distance lead
  wire [48:0] lead_full = 49'(stop_react) * 49'(speed) / 49'h0A;
  wire [31:0] lead = (stop_mode == STOP_OFF) ? 32'h0 : 32'(lead_full);
  wire [31:0] slow_at = ctrl[CTRL_AUTO_DECEL_BIT] ? decel_dist + {12'h0, min_slow}
                                                   : {12'h0, min_slow};
  wire stop_point = remain <= lead;
  wire slow_point = two_speed && (remain <= slow_at);
  wire [31:0] err_abs = (past > target) ? past - target : target - past;
  wire in_tol = (stop_mode == STOP_OFF) || (err_abs <= {12'h0, tol});

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_FEED, SEQ_SETTLE, SEQ_REACT, SEQ_DOWN, SEQ_UP
  } seq_t;
  seq_t seq, next_seq;
  machine_state_t mstate, next_mstate;
  logic [16:0] timer;
  logic [16:0] rest_time;
  logic [16:0] hist [1 << AVG_DEPTH_LOG2];
  logic seq_fire;

  always_comb begin
    next_seq = seq;
    next_mstate = MS_HALT;
    unique case (seq)
      SEQ_IDLE: begin
        if (ctrl[CTRL_JOGF_BIT] || ctrl[CTRL_REF_BIT]) next_mstate = MS_JOG_FWD;
        else if (ctrl[CTRL_JOGR_BIT]) next_mstate = MS_JOG_REV;
        if (ctrl[CTRL_GO_BIT] && !tol_err) next_seq = SEQ_FEED;
      end
      SEQ_FEED: begin
        next_mstate = slow_point ? MS_RUN_SLOW : MS_RUN_FAST;
        if (stop_point) begin
          next_mstate = MS_HALT;
          next_seq = SEQ_SETTLE;
        end
      end
      SEQ_SETTLE: begin
        if (!MOVING) next_seq = in_tol ? (flying ? SEQ_REACT : SEQ_DOWN) : SEQ_IDLE;
      end
      SEQ_REACT: if (timer == '0) next_seq = SEQ_DOWN;
      SEQ_DOWN: if (timer == '0) next_seq = SEQ_UP;
      SEQ_UP: if (timer == '0) next_seq = SEQ_IDLE;
      default: next_seq = SEQ_IDLE;
    endcase
  end

  logic [16:0] avg_sum;
  always_comb begin
    avg_sum = '0;
    for (int i = 0; i < (1 << AVG_DEPTH_LOG2); i++) avg_sum = avg_sum + (hist[i] >> AVG_DEPTH_LOG2);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      seq <= SEQ_IDLE;
      mstate <= MS_HALT;
      timer <= '0;
      rest_time <= '0;
      tol_err <= 1'b0;
      busy_flag <= 1'b0;
      stop_react <= '0;
      for (int i = 0; i < (1 << AVG_DEPTH_LOG2); i++) hist[i] <= '0;
    end else if (CE) begin
      seq <= next_seq;
      mstate <= next_mstate;
      busy_flag <= (next_seq != SEQ_IDLE);
      if (seq == SEQ_SETTLE && !MOVING && !in_tol) tol_err <= 1'b1;
      else if (ctrl[CTRL_ERR_CLR_BIT]) tol_err <= 1'b0;
      if (seq == SEQ_FEED && stop_point) rest_time <= '0;
      else if (seq == SEQ_SETTLE && sub_tick && rest_time != STOP_REACT_MAX)
        rest_time <= rest_time + 17'h1;
      if (seq == SEQ_SETTLE && !MOVING && stop_mode == STOP_AUTO) begin
        for (int i = (1 << AVG_DEPTH_LOG2) - 1; i > 0; i--) hist[i] <= hist[i-1];
        hist[0] <= rest_time;
      end
      // manual mode keeps the entered value untouched
      if (stop_react_wr) stop_react <= 17'(clamp(wv_any, 32'h0, 32'(STOP_REACT_MAX)));
      else if (seq == SEQ_IDLE && stop_mode == STOP_AUTO && det_rise)
        stop_react <= 17'(clamp(32'(avg_sum), 32'h0, 32'(STOP_REACT_MAX)));
      if (seq != next_seq) begin
        unique case (next_seq)
          SEQ_REACT: timer <= {4'h0, press_vee ? v_react : end_react};
          SEQ_DOWN: timer <= {3'h0, press_vee ? v_press_down_time : end_press_down_time};
          SEQ_UP: timer <= {3'h0, press_vee ? v_up_time : end_up_time};
          default: timer <= '0;
        endcase
      end else if (tick && timer != '0) begin
        timer <= timer - 17'h1;
      end
    end
  end
  assign seq_fire = (seq == SEQ_REACT) || (seq == SEQ_DOWN);

  // output encoding; jog and reference never use slow
  wire p_fwd = (mstate == MS_RUN_FAST) || (mstate == MS_JOG_FWD) ||
               (mstate == MS_RUN_SLOW && !fast_slow);
  wire p_slow = (mstate == MS_RUN_SLOW) || (mstate == MS_HALT && !fast_slow);
  wire p_rev = (mstate == MS_JOG_REV);
  wire p_run = (mstate == MS_RUN_FAST) || (mstate == MS_RUN_SLOW);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      OUT_FWD <= 1'b0;
      OUT_SLOW <= 1'b0;
      OUT_REV <= 1'b0;
      OUT_RUN <= 1'b0;
      END_PRESS <= 1'b0;
      V_PRESS <= 1'b0;
      TOL_ERROR <= 1'b0;
    end else if (CE) begin
      OUT_FWD <= p_fwd;
      OUT_SLOW <= p_slow;
      OUT_REV <= p_rev;
      OUT_RUN <= p_run;
      END_PRESS <= seq_fire && !press_vee;
      V_PRESS <= seq_fire && press_vee;
      TOL_ERROR <= tol_err;
    end
  end

endmodule // notcher_feed_press_control
`default_nettype wire

// *** hw/notcher_pkg.sv ***
/*
  notcher_pkg: register map, field layout, reset values and timing counts
  for the feed-to-stop notcher control block.
  assumes a 100 MHz system clock and a 32-bit classic wishbone register bus.
*/
package notcher_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

  // byte offsets on the register bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] END_DOWN_OFFSET = 8'h08;
  localparam logic [7:0] END_UP_OFFSET = 8'h0C;
  localparam logic [7:0] V_DOWN_OFFSET = 8'h10;
  localparam logic [7:0] V_UP_OFFSET = 8'h14;
  localparam logic [7:0] END_REACT_OFFSET = 8'h18;
  localparam logic [7:0] V_REACT_OFFSET = 8'h1C;
  localparam logic [7:0] LEAD_OFFSET = 8'h20;
  localparam logic [7:0] TRAIL_OFFSET = 8'h24;
  localparam logic [7:0] V_DIE_OFFSET = 8'h28;
  localparam logic [7:0] TOL_OFFSET = 8'h2C;
  localparam logic [7:0] MIN_SLOW_OFFSET = 8'h30;
  localparam logic [7:0] STOP_REACT_OFFSET = 8'h34;
  localparam logic [7:0] TARGET_OFFSET = 8'h38;
  localparam logic [7:0] POS_OFFSET = 8'h3C;
  localparam logic [7:0] SPEED_OFFSET = 8'h40;
  localparam logic [7:0] DECEL_OFFSET = 8'h44;

  // control register fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_JOGF_BIT = 1;
  localparam int CTRL_JOGR_BIT = 2;
  localparam int CTRL_PRESS_SEL_BIT = 3;
  localparam int CTRL_TWO_SPEED_BIT = 4;
  localparam int CTRL_FAST_SLOW_BIT = 5;
  localparam int CTRL_STOP_MODE_LSB = 6;
  localparam int CTRL_AUTO_DECEL_BIT = 8;
  localparam int CTRL_FLYING_BIT = 9;
  localparam int CTRL_ERR_CLR_BIT = 10;
  localparam int CTRL_REF_BIT = 11;

  // stop mode codes
  localparam logic [1:0] STOP_AUTO = 2'h0;
  localparam logic [1:0] STOP_MANUAL = 2'h1;
  localparam logic [1:0] STOP_OFF = 2'h2;

  // limits, times in ms, lengths in 0.0001 inch, stop reaction in 0.1 ms
  localparam logic [13:0] DWELL_MIN = 14'h0001;
  localparam logic [13:0] DWELL_MAX = 14'h270F;
  localparam logic [13:0] DWELL_RESET = 14'h0001;
  localparam logic [12:0] REACT_MAX = 13'h01F4;
  localparam logic [19:0] TOL_MIN = 20'h00005;
  localparam logic [19:0] TOL_MAX = 20'h186A0;
  localparam logic [19:0] TOL_RESET = 20'h003E8;
  localparam logic [16:0] STOP_REACT_MAX = 17'h1869F;
  localparam int AVG_DEPTH_LOG2 = 2;

  typedef enum logic [2:0] {
    MS_HALT, MS_RUN_FAST, MS_RUN_SLOW, MS_JOG_FWD, MS_JOG_REV
  } machine_state_t;

endpackage

// *** sim/feed_line_model.sv ***
/*
  feed_line_model: feed drive, detect switch and material motion.
  assumes registered feed outputs from the notcher on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module feed_line_model #(
  parameter int COAST = 20
) (
  input wire logic clk,
  input wire logic zero,
  input wire logic fwd,
  input wire logic slow,
  input wire logic rev,
  input wire logic run,
  output logic [31:0] position,
  output logic moving,
  output logic detect
);
  logic [7:0] coast;
  wire logic cmd = fwd || rev || (slow && run);
  wire logic [31:0] step = rev ? 32'hFFFFFFFE : ((fwd && !slow) ? 32'h2 : 32'h1);
  // line keeps rolling forward after outputs drop, so every forward stop overshoots
  always_ff @(posedge clk) begin
    if (zero) begin
      position <= 32'h0;
      coast <= 8'h0;
    end else if (cmd) begin
      position <= position + step;
      coast <= 8'(COAST);
    end else if (coast != 8'h0) begin
      position <= position + 32'h1;
      coast <= coast - 8'h1;
    end
  end
  assign moving = cmd || (coast != 8'h0);
  // material leaves the switch only while a new part is loaded
  assign detect = !zero;
endmodule // feed_line_model
`default_nettype wire

// *** sim/notcher_feed_press_control_monitor.sv ***
/*
  notcher_feed_press_control_monitor: port assertions and covers.
  assumes a bind onto the notcher top, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module notcher_feed_press_control_monitor (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic MOVING,
  input wire logic OUT_FWD,
  input wire logic OUT_SLOW,
  input wire logic OUT_REV,
  input wire logic OUT_RUN,
  input wire logic END_PRESS,
  input wire logic V_PRESS,
  input wire logic TOL_ERROR
);
  default clocking mclk @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;
  wire logic ctrl_wr = WB_CYC_I && WB_STB_I && WB_WE_I && (WB_ADR_I == 8'h00);
  wire logic drive = OUT_FWD || OUT_REV || OUT_RUN;
  wire logic press = END_PRESS || V_PRESS;
  chk_ack_follows: assert property (req |=> WB_ACK_O)
    else $error("no ack after request");
  chk_ack_pulse: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_data_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero outside ack");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !RSTN && CE |=> !(drive || OUT_SLOW || press || TOL_ERROR))
    else $error("output active after reset edge");
  chk_rev_alone: assert property (OUT_REV |-> !(OUT_FWD || OUT_SLOW || OUT_RUN))
    else $error("reverse driven with other outputs");
  chk_fwd_slow_run: assert property (OUT_FWD && OUT_SLOW |-> OUT_RUN)
    else $error("forward and slow without run");
  chk_press_at_rest: assert property ($rose(press) |-> !MOVING && !drive)
    else $error("press fired while moving");
  chk_press_single: assert property (!(END_PRESS && V_PRESS))
    else $error("both presses at once");
  chk_press_no_err: assert property (press |-> !TOL_ERROR)
    else $error("press with tolerance error");
  chk_err_halts: assert property ($rose(TOL_ERROR) |-> !drive)
    else $error("error raised while driving");
  chk_err_sticky: assert property ($fell(TOL_ERROR) |->
    $past(ctrl_wr, 1) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("error dropped without clear");
  cov_end: cover property ($rose(END_PRESS));
  cov_vee: cover property ($rose(V_PRESS));
  cov_err: cover property ($rose(TOL_ERROR));
  cov_slow: cover property (OUT_SLOW && OUT_RUN && !OUT_FWD);
endmodule // notcher_feed_press_control_monitor
`default_nettype wire

// *** sim/notcher_feed_press_control_tb_top.sv ***
/*
  notcher_feed_press_control_tb_top: self-checking bench, one task per scenario.
  assumes the feed line model on the far side and a 10-cycle tick.
*/
`timescale 1ns/1ps
`default_nettype none
module notcher_feed_press_control_tb_top import notcher_pkg::*; ;
  localparam int TICK = 10;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic zero = 1'b1;
  logic [31:0] dat_o;
  logic [31:0] position;
  logic ack, detect, moving, fwd, slow, rev, run, end_p, v_p, tol_err;
  int err_count = 0;
  int check_count = 0;
  always #5 sys_clk = ~sys_clk;
  notcher_feed_press_control #(.TICK_LEN(TICK), .POS_W(32)) dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .CE(1'b1), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_ACK_O(ack), .DETECT(detect), .POSITION(position), .MOVING(moving), .OUT_FWD(fwd),
    .OUT_SLOW(slow), .OUT_REV(rev), .OUT_RUN(run), .END_PRESS(end_p), .V_PRESS(v_p),
    .TOL_ERROR(tol_err));
  feed_line_model #(.COAST(20)) model (.clk(sys_clk), .zero(zero), .fwd(fwd), .slow(slow),
    .rev(rev), .run(run), .position(position), .moving(moving), .detect(detect));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // entered just after a rising edge; holds the request until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      check("bus ack", 32'h0, 32'h1);
      final_report();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic outs(input string name, input logic [3:0] e);
    repeat (3) @(negedge sys_clk);
    check(name, {28'h0, fwd, slow, rev, run}, {28'h0, e});
    @(posedge sys_clk);
  endtask
  task automatic feed(input logic [31:0] ctrl, output int s, output int p, output bit f);
    int n;
    s = -1;
    p = -1;
    f = 1'b0;
    n = 0;
    zero <= 1'b1;
    @(posedge sys_clk);
    zero <= 1'b0;
    wr(CTRL_OFFSET, ctrl | 32'h1);
    while (p < 0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
      if (fwd && !slow && run) f = 1'b1;
      if (slow && run && !fwd && s < 0) s = position;
      if (f && !fwd && !run) p = position;
    end
    if (n >= 2000) begin
      check("feed stop", 32'h0, 32'h1);
      final_report();
    end
    @(posedge sys_clk);
  endtask
  // press length in cycles, 0 when no press came
  task automatic press_len(input bit vee, output int w);
    int n;
    n = 0;
    w = 0;
    while ((vee ? v_p : end_p) !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    while ((vee ? v_p : end_p) === 1'b1 && w < 400) begin
      @(negedge sys_clk);
      w++;
    end
    repeat (40) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    wb(TOL_OFFSET, 1'b0, 32'h0, q);
    check("tolerance reset", q, 32'(TOL_RESET));
    wb(CTRL_OFFSET, 1'b0, 32'h0, q);
    check("stop mode reset", 32'(q[7:6]), 32'(STOP_AUTO));
    wb(END_DOWN_OFFSET, 1'b0, 32'h0, q);
    check("down time reset", q, 32'(DWELL_RESET));
    wb(8'hFC, 1'b0, 32'h0, q);
    check("unmapped read", q, 32'h0);
    outs("halt outputs", 4'b0100);
    $display("test reset done");
  endtask
  task automatic t_limits();
    logic [7:0] a [13] = '{END_DOWN_OFFSET, END_DOWN_OFFSET, V_DOWN_OFFSET, END_UP_OFFSET,
      V_UP_OFFSET, END_REACT_OFFSET, V_REACT_OFFSET, LEAD_OFFSET, TRAIL_OFFSET,
      V_DIE_OFFSET, TOL_OFFSET, TOL_OFFSET, STOP_REACT_OFFSET};
    logic [31:0] d [13] = '{32'h0, 32'h2710, 32'h0, 32'h3E7, 32'h123, 32'h1F5, 32'h3FF,
      32'h1111, 32'h2222, 32'h3333, 32'h0, 32'h186A1, 32'h186A0};
    logic [31:0] e [13] = '{32'(DWELL_MIN), 32'(DWELL_MAX), 32'(DWELL_MIN), 32'h3E7, 32'h123,
      32'(REACT_MAX), 32'(REACT_MAX), 32'h1111, 32'h2222, 32'h3333, 32'(TOL_MIN),
      32'(TOL_MAX), 32'(STOP_REACT_MAX)};
    logic [31:0] q;
    for (int i = 0; i < 13; i++) begin
      wr(a[i], d[i]);
      wb(a[i], 1'b0, 32'h0, q);
      check("register limit", q, e[i]);
    end
    $display("test limits done");
  endtask
  task automatic t_jog();
    logic [31:0] b;
    for (int m = 0; m < 2; m++) begin
      b = 32'h10 | (32'(m) << 5);
      wr(CTRL_OFFSET, b | 32'h2);
      outs("jog forward", 4'b1000);
      wr(CTRL_OFFSET, b | 32'h4);
      outs("jog reverse", 4'b0010);
      wr(CTRL_OFFSET, b);
      outs("halt", (m == 0) ? 4'b0100 : 4'b0000);
    end
    $display("test jog done");
  endtask
  task automatic t_feed_off();
    int s, p, w;
    bit f;
    wr(TARGET_OFFSET, 32'd200);
    wr(MIN_SLOW_OFFSET, 32'd50);
    wr(TOL_OFFSET, 32'd5);
    wr(END_DOWN_OFFSET, 32'd3);
    wr(V_DOWN_OFFSET, 32'd3);
    // short up strokes, so the next feed never meets a busy press
    wr(END_UP_OFFSET, 32'd3);
    wr(V_UP_OFFSET, 32'd3);
    for (int i = 0; i < 5; i++) wr(END_REACT_OFFSET + 8'(4 * i), 32'h0);
    feed(32'hB0, s, p, f);
    check("fast phase", 32'(f), 32'h1);
    check("slow start", 32'(s >= 146 && s <= 154), 32'h1);
    check("stop point", 32'(p >= 200 && p <= 204), 32'h1);
    press_len(1'b0, w);
    check("end press length", 32'(w >= 2 * TICK && w <= 3 * TICK + 2), 32'h1);
    check("tolerance skipped", {31'h0, tol_err}, 32'h0);
    $display("test feed off done");
  endtask
  task automatic t_feed_tol();
    int s, p, w;
    bit f;
    logic [31:0] q;
    wr(STOP_REACT_OFFSET, 32'h1);
    feed(32'h70, s, p, f);
    press_len(1'b0, w);
    check("press held back", 32'(w), 32'h0);
    check("tolerance error", {31'h0, tol_err}, 32'h1);
    wb(STOP_REACT_OFFSET, 1'b0, 32'h0, q);
    check("manual reaction kept", q, 32'h1);
    // fresh part at zero, so an accepted go would start the feed at once
    zero <= 1'b1;
    @(posedge sys_clk);
    zero <= 1'b0;
    wr(CTRL_OFFSET, 32'h71);
    outs("go refused", 4'b0000);
    wr(CTRL_OFFSET, 32'h470);
    @(negedge sys_clk);
    check("error cleared", {31'h0, tol_err}, 32'h0);
    feed(32'hB8, s, p, f);
    press_len(1'b1, w);
    check("vee press length", 32'(w >= 2 * TICK && w <= 3 * TICK + 2), 32'h1);
    $display("test feed tolerance done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    zero <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_limits();
    t_jog();
    t_feed_off();
    t_feed_tol();
    final_report();
  end
endmodule // notcher_feed_press_control_tb_top
bind notcher_feed_press_control notcher_feed_press_control_monitor mon (.SYS_CLK(SYS_CLK),
  .RSTN(RSTN), .CE(CE), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .MOVING(MOVING),
  .OUT_FWD(OUT_FWD), .OUT_SLOW(OUT_SLOW), .OUT_REV(OUT_REV), .OUT_RUN(OUT_RUN),
  .END_PRESS(END_PRESS), .V_PRESS(V_PRESS), .TOL_ERROR(TOL_ERROR));
`default_nettype wire
